// ===== core/dual_issue_integer_pipeline.sv
// Control for a dual-issue integer pipeline: prefetch buffers, optional length
// decode and instruction FIFO, paired decode, address generation, execute, writeback.
// Assumes the code cache answers fetches and a parser delivers up to two descriptors.
`timescale 1ns/10ps

module dual_issue_integer_pipeline #(
    parameter bit EXTENDED = 1'b0   // Zero for base variant, one for extended.
) (
    input  wire logic        clk,            // Core clock.
    input  wire logic        rst,            // Asynchronous reset, active high.
    output logic             fetch_req,      // Fetch request to the code cache.
    output logic [1:0]       fetch_buf,      // Prefetch buffer issuing the request.
    output logic [31:0]      fetch_addr,     // Line address requested.
    input  wire logic        cache_ack,      // Requested line delivered.
    input  wire logic        cache_branch,   // Delivered line holds a branch.
    input  wire logic        btb_taken,      // Branch target buffer predicts taken.
    input  wire logic [31:0] btb_target,     // Predicted target address.
    output logic             in_ready,       // Descriptor pair may be offered.
    input  wire logic [1:0]  in_valid,       // Slot valid; slot one implies slot zero.
    input  wire logic [1:0]  in_simple,      // Slot is a simple instruction.
    input  wire logic [3:0]  in_prefixes,    // Prefix count per slot, two bits each.
    input  wire logic [1:0]  in_esc_0f,      // Slot carries the 0Fh escape.
    input  wire logic [1:0]  in_near_jcc,    // Slot is a near conditional jump.
    input  wire logic [1:0]  in_branch,      // Slot is a branch.
    input  wire logic [1:0]  in_cond,        // Branch is conditional.
    input  wire logic [1:0]  in_disp_imm,    // Slot has displacement and immediate.
    input  wire logic [1:0]  in_alu_mem,     // Slot needs ALU and data cache.
    input  wire logic [1:0]  in_pred_taken,  // Slot branch predicted taken.
    input  wire logic [1:0]  in_long,        // Slot is a long instruction.
    input  wire logic        in_misaligned,  // Pair starts at a misaligned target.
    input  wire logic [1:0]  in_dst_en,      // Slot writes a register.
    input  wire logic [7:0]  in_dst,         // Destination register per slot.
    input  wire logic [7:0]  in_src_a,       // First source register per slot.
    input  wire logic [7:0]  in_src_b,       // Second source register per slot.
    input  wire logic        d1_stall,       // External hold at first decode.
    input  wire logic        d2_stall,       // External hold at address generation.
    input  wire logic        ex_u_stall,     // Primary pipe execute hold.
    input  wire logic        ex_v_stall,     // Secondary pipe execute hold.
    input  wire logic        ex_u_taken,     // Resolved outcome of primary branch.
    input  wire logic        ex_v_taken,     // Resolved outcome of secondary branch.
    input  wire logic        wb_v_taken,     // Resolved outcome of secondary cond branch.
    input  wire logic [31:0] ex_fix_addr,    // Correct path for an execute mismatch.
    input  wire logic [31:0] wb_fix_addr,    // Correct path for a writeback mismatch.
    output logic             issue_u,        // Instruction issued to primary pipe.
    output logic             issue_v,        // Instruction issued to secondary pipe.
    output logic             issue_prefix,   // Primary issue was a prefix.
    output logic             d2_u_valid,     // Primary address stage occupied.
    output logic             d2_v_valid,     // Secondary address stage occupied.
    output logic             ex_u_valid,     // Primary execute stage occupied.
    output logic             ex_v_valid,     // Secondary execute stage occupied.
    output logic             wb_u_valid,     // Primary writeback stage occupied.
    output logic             wb_v_valid,     // Secondary writeback stage occupied.
    output logic             flush,          // Pipes flushed, one-cycle pulse.
    output logic [31:0]      restart_addr    // Address fetching restarted at.
);

    dual_issue_pkg::state_t s;
    dual_issue_pkg::state_t next_s;

    always_comb
    begin
        dual_issue_pkg::desc_t [5:0] list;
        dual_issue_pkg::desc_t [1:0] src;
        dual_issue_pkg::desc_t       h0;
        dual_issue_pkg::desc_t       h1;
        dual_issue_pkg::desc_t [1:0] inp;
        logic [31:0] line;
        logic [1:0]  last_buf;
        logic [2:0]  cap;
        logic [2:0]  scnt;
        logic [2:0]  total;
        logic [2:0]  n_iss;
        logic [2:0]  wait_in;
        logic        src_ok;
        logic        take;
        logic        pair;
        logic        can_issue;
        logic        ex_any;
        logic        ex_hold;
        logic        ex_move;
        logic        d2_any;
        logic        d2_move;
        logic        d2_free;
        logic        mis_ex;
        logic        mis_wb;
        logic        raw_waw;
        list      = '0;
        src       = '0;
        h0        = '0;
        h1        = '0;
        inp       = '0;
        scnt      = 3'h0;
        total     = 3'h0;
        n_iss     = 3'h0;
        take      = 1'b0;
        pair      = 1'b0;
        raw_waw   = 1'b0;
        next_s    = s;
        next_s.flush        = 1'b0;
        next_s.issue_u      = 1'b0;
        next_s.issue_v      = 1'b0;
        next_s.issue_prefix = 1'b0;

        line     = EXTENDED ? dual_issue_pkg::LINE_BYTES_EXT : dual_issue_pkg::LINE_BYTES_BASE;
        last_buf = EXTENDED ? dual_issue_pkg::LAST_BUF_EXT : dual_issue_pkg::LAST_BUF_BASE;
        cap      = EXTENDED ? dual_issue_pkg::QUEUE_CAP_EXT : dual_issue_pkg::QUEUE_CAP_BASE;

        // Only the active buffer requests; a predicted taken branch hands over.
        if (s.fetch_req && cache_ack)
        begin
            if (cache_branch && btb_taken)
            begin
                next_s.active = (s.active == last_buf) ? 2'h0 : s.active + 2'h1;
                next_s.fetch_addr[next_s.active] = btb_target & ~(line - 32'h1);
            end
            else
            begin
                next_s.fetch_addr[s.active] = s.fetch_addr[s.active] + line;
            end
        end
        next_s.fetch_req = 1'b1;

        // Execute: either pipe's stall holds both, plus the extra ALU-and-cache clock.
        ex_any  = s.ex_u.valid | s.ex_v.valid;
        ex_hold = (ex_u_stall & s.ex_u.valid) | (ex_v_stall & s.ex_v.valid) | s.ex_extra;
        ex_move = ex_any & ~ex_hold;
        next_s.ex_extra = 1'b0;
        next_s.wb_u = ex_move ? s.ex_u : '0;
        next_s.wb_v = ex_move ? s.ex_v : '0;

        // Secondary conditional branches are verified one stage later than the rest.
        mis_ex = ex_move & ((s.ex_u.valid & s.ex_u.branch & (ex_u_taken != s.ex_u.pred_taken))
               | (s.ex_v.valid & s.ex_v.branch & ~s.ex_v.cond
                  & (ex_v_taken != s.ex_v.pred_taken)));
        mis_wb = s.wb_v.valid & s.wb_v.branch & s.wb_v.cond
               & (wb_v_taken != s.wb_v.pred_taken);

        // Address generation feeds execute only when both execute slots clear.
        d2_any  = s.d2_u.valid | s.d2_v.valid;
        d2_move = d2_any & ~d2_stall & (~ex_any | ex_move);
        d2_free = ~d2_any | d2_move;
        if (d2_move)
        begin
            next_s.ex_u     = s.d2_u;
            next_s.ex_v     = s.d2_v;
            next_s.ex_extra = (s.d2_u.alu_mem | s.d2_v.alu_mem) & dual_issue_pkg::EX_EXTRA_CYCLES;
        end
        else if (ex_move)
        begin
            next_s.ex_u = '0;
            next_s.ex_v = '0;
        end

        // Source of new descriptors for the decode window.
        if (EXTENDED)
        begin
            src    = s.ld_slot;
            src_ok = s.ld_slot[0].valid && (s.ld_wait == 3'h0);
        end
        else
        begin
            src    = s.pf_slot;
            src_ok = s.pf_slot[0].valid;
        end
        scnt = src_ok ? {2'h0, src[0].valid} + {2'h0, src[1].valid} : 3'h0;

        // FIFO contents first, then the bypass entries, so an empty FIFO adds no delay.
        for (int i = 0; i < 6; i++)
        begin
            if (i < int'(s.qcnt))
            begin
                list[i] = s.q[i];
            end
            else if (i - int'(s.qcnt) < int'(scnt))
            begin
                list[i] = ((i - int'(s.qcnt)) == 0) ? src[0] : src[1];
            end
        end
        h0 = list[0];
        h1 = list[1];

        // Two decoders look at the next two sequential entries.
        can_issue = h0.valid & d2_free & ~d1_stall;
        raw_waw = h0.dst_en & ((h1.dst_en & (h0.dst == h1.dst))
                | (h0.dst == h1.src_a) | (h0.dst == h1.src_b));
        pair = h1.valid & h0.simple & h1.simple & (h1.pfx == 3'h0) & ~h0.branch
             & ~h0.disp_imm & ~h1.disp_imm & ~raw_waw;
        if (can_issue)
        begin
            next_s.issue_u = 1'b1;
            if (h0.pfx != 3'h0)
            begin
                // A prefix goes alone to the primary pipe and stays counted on its base.
                next_s.issue_prefix = 1'b1;
                next_s.d2_u         = '0;
                next_s.d2_u.valid   = 1'b1;
                next_s.d2_v         = '0;
                list[0].pfx         = h0.pfx - 3'h1;
            end
            else
            begin
                next_s.d2_u    = h0;
                next_s.d2_v    = pair ? h1 : '0;
                next_s.issue_v = pair;
                n_iss          = pair ? 3'h2 : 3'h1;
            end
        end
        else if (d2_move)
        begin
            next_s.d2_u = '0;
            next_s.d2_v = '0;
        end

        // Take the new entries only if what is left still fits.
        total = s.qcnt + scnt;
        take  = src_ok && ((total - n_iss) <= cap);
        total = take ? total : s.qcnt;
        for (int i = 0; i < 4; i++)
        begin
            next_s.q[i] = ((i + int'(n_iss)) < int'(total)) ? list[i + int'(n_iss)] : '0;
        end
        next_s.qcnt = total - n_iss;

        // Extended length decode: prefixes resolved and entry stalls counted down.
        for (int j = 0; j < 2; j++)
        begin
            inp[j].valid      = in_valid[j];
            inp[j].simple     = in_simple[j];
            inp[j].branch     = in_branch[j];
            inp[j].cond       = in_cond[j];
            inp[j].disp_imm   = in_disp_imm[j];
            inp[j].alu_mem    = in_alu_mem[j];
            inp[j].pred_taken = in_pred_taken[j];
            inp[j].dst_en     = in_dst_en[j];
            inp[j].dst        = in_dst[4*j +: 4];
            inp[j].src_a      = in_src_a[4*j +: 4];
            inp[j].src_b      = in_src_b[4*j +: 4];
            // In the base variant the 0Fh escape costs a decode clock unless it opens a near jump.
            inp[j].pfx = {1'b0, in_prefixes[2*j +: 2]}
                       + {2'h0, ~EXTENDED & in_esc_0f[j] & ~in_near_jcc[j]};
        end
        wait_in = {1'b0, in_prefixes[1:0]} + {1'b0, in_prefixes[3:2]}
                + {2'h0, in_long[0] | in_long[1]} + {2'h0, in_misaligned};

        if (EXTENDED)
        begin
            if (take)
            begin
                next_s.ld_slot = '0;
            end
            else if (s.ld_wait != 3'h0)
            begin
                next_s.ld_wait = s.ld_wait - 3'h1;
            end
            if (s.pf_slot[0].valid && (!s.ld_slot[0].valid || take))
            begin
                next_s.ld_slot = s.pf_slot;
                for (int j = 0; j < 2; j++)
                begin
                    next_s.ld_slot[j].pfx = 3'h0;
                end
                next_s.ld_wait = s.pf_wait;
                next_s.pf_slot = '0;
            end
        end
        else if (take)
        begin
            next_s.pf_slot = '0;
        end

        if (s.in_ready && in_valid[0])
        begin
            next_s.pf_slot = inp;
            next_s.pf_wait = wait_in;
        end

        // Oldest mismatch wins; every younger instruction is dropped.
        if (mis_wb || mis_ex)
        begin
            next_s.flush        = 1'b1;
            next_s.restart_addr = mis_wb ? wb_fix_addr : ex_fix_addr;
            next_s.active       = dual_issue_pkg::RESET_ACTIVE_BUF;
            next_s.fetch_addr[dual_issue_pkg::RESET_ACTIVE_BUF] = next_s.restart_addr;
            next_s.pf_slot      = '0;
            next_s.ld_slot      = '0;
            next_s.ld_wait      = 3'h0;
            next_s.q            = '0;
            next_s.qcnt         = 3'h0;
            next_s.d2_u         = '0;
            next_s.d2_v         = '0;
            next_s.ex_u         = '0;
            next_s.ex_v         = '0;
            next_s.ex_extra     = 1'b0;
            next_s.issue_u      = 1'b0;
            next_s.issue_v      = 1'b0;
            next_s.issue_prefix = 1'b0;
            if (mis_wb)
            begin
                next_s.wb_u = '0;
                next_s.wb_v = '0;
            end
            else if (s.ex_u.valid && s.ex_u.branch && (ex_u_taken != s.ex_u.pred_taken))
            begin
                next_s.wb_v = '0;
            end
        end

        next_s.in_ready = ~next_s.pf_slot[0].valid;
        next_s.fetch_line = next_s.fetch_addr[next_s.active];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s              <= '0;
            s.fetch_addr   <= {4{dual_issue_pkg::RESET_FETCH_ADDR}};
            s.active       <= dual_issue_pkg::RESET_ACTIVE_BUF;
            s.restart_addr <= dual_issue_pkg::RESET_FETCH_ADDR;
            s.fetch_line   <= dual_issue_pkg::RESET_FETCH_ADDR;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign fetch_req    = s.fetch_req;
    assign fetch_buf    = s.active;
    assign fetch_addr   = s.fetch_line;
    assign in_ready     = s.in_ready;
    assign issue_u      = s.issue_u;
    assign issue_v      = s.issue_v;
    assign issue_prefix = s.issue_prefix;
    assign d2_u_valid   = s.d2_u.valid;
    assign d2_v_valid   = s.d2_v.valid;
    assign ex_u_valid   = s.ex_u.valid;
    assign ex_v_valid   = s.ex_v.valid;
    assign wb_u_valid   = s.wb_u.valid;
    assign wb_v_valid   = s.wb_v.valid;
    assign flush        = s.flush;
    assign restart_addr = s.restart_addr;

endmodule : dual_issue_integer_pipeline

// ===== pkg/dual_issue_pkg.sv
// Constants and types shared by the dual-issue integer pipeline control.
// Assumes one core clock; instruction descriptors come from an external parser.
package dual_issue_pkg;

    // Prefetch geometry per variant.
    localparam logic [31:0] LINE_BYTES_BASE = 32'h0000_0020;
    localparam logic [31:0] LINE_BYTES_EXT  = 32'h0000_0010;
    localparam logic [1:0]  LAST_BUF_BASE   = 2'h1;
    localparam logic [1:0]  LAST_BUF_EXT    = 2'h3;

    // Decode window or instruction FIFO capacity in entries.
    localparam logic [2:0]  QUEUE_CAP_BASE  = 3'h2;
    localparam logic [2:0]  QUEUE_CAP_EXT   = 3'h4;

    // Values after reset.
    localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
    localparam logic [1:0]  RESET_ACTIVE_BUF = 2'h0;

    // Cycles an instruction needing ALU and cache spends in execute beyond the first.
    localparam logic        EX_EXTRA_CYCLES  = 1'h1;

    typedef struct packed {
        logic       valid;
        logic       simple;
        logic [2:0] pfx;
        logic       branch;
        logic       cond;
        logic       disp_imm;
        logic       alu_mem;
        logic       pred_taken;
        logic       dst_en;
        logic [3:0] dst;
        logic [3:0] src_a;
        logic [3:0] src_b;
    } desc_t;

    typedef struct packed {
        logic [3:0][31:0] fetch_addr;
        logic [1:0]       active;
        logic             fetch_req;
        logic             in_ready;
        desc_t [1:0]      pf_slot;
        logic [2:0]       pf_wait;
        desc_t [1:0]      ld_slot;
        logic [2:0]       ld_wait;
        desc_t [3:0]      q;
        logic [2:0]       qcnt;
        desc_t            d2_u;
        desc_t            d2_v;
        desc_t            ex_u;
        desc_t            ex_v;
        logic             ex_extra;
        desc_t            wb_u;
        desc_t            wb_v;
        logic             issue_u;
        logic             issue_v;
        logic             issue_prefix;
        logic             flush;
        logic [31:0]      restart_addr;
        logic [31:0]      fetch_line;
    } state_t;

endpackage : dual_issue_pkg

// ===== sim/dual_issue_integer_pipeline_monitor.sv
// Port checker for the dual-issue pipeline control.
// Assumes the core clock and the active-high asynchronous reset of the design.
`timescale 1ns/10ps
module dual_issue_integer_pipeline_monitor #(
    parameter bit EXTENDED = 1'b0   // Variant select.
) (
    input wire logic        clk,          // Clock.
    input wire logic        rst,          // Reset.
    input wire logic        fetch_req,    // Fetch on.
    input wire logic [1:0]  fetch_buf,    // Buffer.
    input wire logic [31:0] fetch_addr,   // Line.
    input wire logic        cache_ack,    // Delivered.
    input wire logic        cache_branch, // Branch.
    input wire logic        btb_taken,    // Taken.
    input wire logic [31:0] btb_target,   // Target.
    input wire logic        issue_u,      // U issue.
    input wire logic        issue_v,      // V issue.
    input wire logic        issue_prefix, // Prefix.
    input wire logic        d2_u_valid,   // U addr.
    input wire logic        d2_v_valid,   // V addr.
    input wire logic        ex_u_valid,   // U exec.
    input wire logic        ex_v_valid,   // V exec.
    input wire logic        ex_u_stall,   // U hold.
    input wire logic        ex_v_stall,   // V hold.
    input wire logic        flush,        // Flush.
    input wire logic [31:0] restart_addr  // Restart.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] line;
    logic [1:0]  wrap;
    assign line = EXTENDED ? dual_issue_pkg::LINE_BYTES_EXT : dual_issue_pkg::LINE_BYTES_BASE;
    assign wrap = EXTENDED ? dual_issue_pkg::LAST_BUF_EXT : dual_issue_pkg::LAST_BUF_BASE;
    sequence s_ack;
        fetch_req && cache_ack;
    endsequence
    sequence s_taken;
        s_ack ##0 (cache_branch && btb_taken);
    endsequence
    fetch_seq_a: assert property (s_ack ##0 !(cache_branch && btb_taken) |=> flush ||
        (fetch_addr == $past(fetch_addr) + line && $stable(fetch_buf)))
        else $error("sequential fetch address wrong");
    fetch_taken_a: assert property (s_taken |=> flush ||
        (fetch_buf == (($past(fetch_buf) + 2'h1) & wrap)
        && fetch_addr == ($past(btb_target) & ~(line - 32'h1))))
        else $error("taken branch buffer switch wrong");
    flush_restart_a: assert property (flush |-> fetch_buf == 2'h0 && fetch_addr == restart_addr)
        else $error("restart fetch wrong");
    flush_clear_a: assert property (flush |-> !d2_u_valid && !ex_u_valid ##1 !flush)
        else $error("flush left stages busy");
    prefix_alone_a: assert property (issue_prefix |-> issue_u && !issue_v)
        else $error("prefix not alone in primary");
    issue_d2_a: assert property (issue_v |-> issue_u && d2_u_valid && d2_v_valid)
        else $error("secondary issue without primary");
    ex_pair_a: assert property (ex_v_valid |-> ex_u_valid)
        else $error("secondary execute alone");
    ex_hold_a: assert property (ex_u_valid && (ex_u_stall || ex_v_valid && ex_v_stall)
        |=> flush || (ex_u_valid && ex_v_valid == $past(ex_v_valid)))
        else $error("execute stall did not hold pair");
endmodule : dual_issue_integer_pipeline_monitor
bind dual_issue_integer_pipeline dual_issue_integer_pipeline_monitor #(.EXTENDED(EXTENDED)) mon (
    .clk, .rst, .fetch_req, .fetch_buf, .fetch_addr, .cache_ack, .cache_branch, .btb_taken,
    .btb_target, .issue_u, .issue_v, .issue_prefix, .d2_u_valid, .d2_v_valid, .ex_u_valid,
    .ex_v_valid, .ex_u_stall, .ex_v_stall, .flush, .restart_addr);

// ===== sim/code_cache_model.sv
// Code cache and branch predictor stand-in at the fetch port.
// Assumes the bench sets the branch knobs before each delivery.
`timescale 1ns/10ps
module code_cache_model (
    input  wire logic        clk,          // Clock.
    input  wire logic        rst,          // Reset.
    input  wire logic        fetch_req,    // Fetch on.
    input  wire logic [1:0]  gap,          // Idle cycles.
    input  wire logic        br,           // Line has branch.
    input  wire logic        tk,           // Predict taken.
    input  wire logic [31:0] tgt,          // Target.
    output logic             cache_ack,    // Delivered.
    output logic             cache_branch, // Branch.
    output logic             btb_taken,    // Taken.
    output logic [31:0]      btb_target    // Target.
);
    logic [1:0] cnt;
    // Between deliveries the sideband toggles so stale values never look valid.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 2'h0;
            cache_ack <= 1'b0;
            {cache_branch, btb_taken, btb_target} <= '0;
        end
        else if (fetch_req && !cache_ack && cnt == gap)
        begin
            cache_ack <= 1'b1;
            {cache_branch, btb_taken, btb_target} <= {br, tk, tgt};
        end
        else
        begin
            cnt <= cache_ack ? 2'h0 : cnt + 2'h1;
            cache_ack <= 1'b0;
            {cache_branch, btb_taken, btb_target} <= ~{cache_branch, btb_taken, btb_target};
        end
    end
endmodule : code_cache_model

// ===== sim/dual_issue_integer_pipeline_tb_top.sv
// Self-checking bench for the dual-issue pipeline control, base variant.
// Assumes the cache model and the bound port checker.
`timescale 1ns/10ps
module dual_issue_integer_pipeline_tb_top;
    logic        clk, rst, fetch_req, cache_ack, cache_branch, btb_taken, in_ready, in_misaligned;
    logic        d1_stall, d2_stall, ex_u_stall, ex_v_stall, ex_u_taken, ex_v_taken, wb_v_taken;
    logic        issue_u, issue_v, issue_prefix, d2_u_valid, d2_v_valid, ex_u_valid, ex_v_valid;
    logic        wb_u_valid, wb_v_valid, flush, br, tk;
    logic [1:0]  fetch_buf, gap, in_valid, in_simple, in_esc_0f, in_near_jcc, in_branch, in_cond;
    logic [1:0]  in_disp_imm, in_alu_mem, in_pred_taken, in_long, in_dst_en;
    logic [3:0]  in_prefixes;
    logic [7:0]  in_dst, in_src_a, in_src_b;
    logic [31:0] fetch_addr, btb_target, ex_fix_addr, wb_fix_addr, restart_addr, tgt;
    int          n_mismatch = 0;
    int          tests_run = 0;
    dual_issue_integer_pipeline #(.EXTENDED(1'b0)) dut (.clk, .rst, .fetch_req, .fetch_buf,
        .fetch_addr, .cache_ack, .cache_branch, .btb_taken, .btb_target, .in_ready, .in_valid,
        .in_simple, .in_prefixes, .in_esc_0f, .in_near_jcc, .in_branch, .in_cond, .in_disp_imm,
        .in_alu_mem, .in_pred_taken, .in_long, .in_misaligned, .in_dst_en, .in_dst, .in_src_a,
        .in_src_b, .d1_stall, .d2_stall, .ex_u_stall, .ex_v_stall, .ex_u_taken, .ex_v_taken,
        .wb_v_taken, .ex_fix_addr, .wb_fix_addr, .issue_u, .issue_v, .issue_prefix, .d2_u_valid,
        .d2_v_valid, .ex_u_valid, .ex_v_valid, .wb_u_valid, .wb_v_valid, .flush, .restart_addr);
    code_cache_model cache (.clk, .rst, .fetch_req, .gap, .br, .tk, .tgt, .cache_ack,
        .cache_branch, .btb_taken, .btb_target);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim();
        $display("compared %0d mismatched %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic pick(input int s);
        case (s)
            0: return issue_u;
            1: return flush;
            2: return ex_u_valid;
            3: return in_ready;
            default: return cache_ack && fetch_req;
        endcase
    endfunction : pick
    // Values read just after an edge are those the design sampled at it.
    task automatic wait_on(input int s, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pick(s) !== 1'b1 && n < 60);
        if (pick(s) !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD t=%0t wait %h got %h", $time, s, 0);
            end_sim();
        end
    endtask : wait_on
    task automatic offer(input logic [1:0] v);
        int n;
        in_valid <= v;
        wait_on(3, n);
        in_valid <= 2'h0;
    endtask : offer
    task automatic test_fetch();
        logic [31:0] a;
        logic [1:0]  b;
        int          n;
        for (int i = 0; i < 6; i++)
        begin
            br <= (i > 2);
            tk <= (i > 3);
            tgt <= 32'h0000_1234 + i * 32'h0000_2000;
            wait_on(4, n);
            a = (i > 3) ? tgt & ~32'h1f : fetch_addr + dual_issue_pkg::LINE_BYTES_BASE;
            b = (i > 3) ? ~fetch_buf & 2'h1 : fetch_buf;
            @(posedge clk);
            chk(fetch_addr, a);
            chk(fetch_buf, b);
        end
        br <= 1'b0;
        $display("test_fetch done");
    endtask : test_fetch
    task automatic test_pair(input logic [7:0] sa, input logic [1:0] sim, input logic pv);
        int n;
        in_src_a <= sa;
        in_simple <= sim;
        offer(2'h3);
        wait_on(0, n);
        chk(issue_v, pv);
        chk({d2_u_valid, d2_v_valid}, {1'b1, pv});
        if (!pv)
        begin
            wait_on(0, n);
            chk(n, 1);
        end
        @(posedge clk);
        chk({ex_u_valid, ex_v_valid}, {1'b1, pv});
        @(posedge clk);
        chk({wb_u_valid, wb_v_valid}, {1'b1, pv});
        {in_src_a, in_simple} <= {8'h43, 2'h3};
        @(posedge clk);
        $display("test_pair done");
    endtask : test_pair
    task automatic test_prefix(input logic [1:0] p, input logic esc, input logic jcc, input int np);
        int n;
        in_prefixes <= {2'h0, p};
        in_esc_0f <= {1'b0, esc};
        in_near_jcc <= {1'b0, jcc};
        offer(2'h3);
        for (int k = 0; k < np; k++)
        begin
            wait_on(0, n);
            chk({issue_prefix, issue_v}, 2'h2);
        end
        wait_on(0, n);
        chk({issue_prefix, issue_v}, 2'h1);
        {in_prefixes, in_esc_0f, in_near_jcc} <= '0;
        @(posedge clk);
        $display("test_prefix done");
    endtask : test_prefix
    task automatic test_ex();
        int n;
        in_alu_mem <= 2'h1;
        offer(2'h3);
        wait_on(2, n);
        @(posedge clk);
        chk(ex_u_valid, 1);
        @(posedge clk);
        chk(ex_u_valid, 0);
        in_alu_mem <= 2'h0;
        ex_v_stall <= 1'b1;
        offer(2'h3);
        wait_on(2, n);
        repeat (3) @(posedge clk);
        chk({ex_u_valid, ex_v_valid}, 2'h3);
        ex_v_stall <= 1'b0;
        repeat (2) @(posedge clk);
        chk({ex_u_valid, wb_u_valid, wb_v_valid}, 3'h3);
        $display("test_ex done");
    endtask : test_ex
    task automatic test_miss(input logic vp, input int en);
        int n;
        in_branch <= vp ? 2'h2 : 2'h1;
        in_cond <= vp ? 2'h2 : 2'h1;
        {ex_u_taken, ex_v_taken, wb_v_taken} <= {!vp, vp, vp};
        ex_fix_addr <= 32'h0000_4000;
        wb_fix_addr <= 32'h0000_8000;
        offer(vp ? 2'h3 : 2'h1);
        wait_on(0, n);
        wait_on(1, n);
        chk(n, en);
        chk(restart_addr, vp ? 32'h0000_8000 : 32'h0000_4000);
        chk(fetch_addr, vp ? 32'h0000_8000 : 32'h0000_4000);
        {in_branch, in_cond, ex_u_taken, ex_v_taken, wb_v_taken} <= '0;
        @(posedge clk);
        $display("test_miss done");
    endtask : test_miss
    initial
    begin
        rst = 1'b1;
        {in_valid, in_esc_0f, in_near_jcc, in_branch, in_cond, in_disp_imm, in_alu_mem} = '0;
        {in_pred_taken, in_long, in_misaligned, in_prefixes, br, tk, tgt} = '0;
        {d1_stall, d2_stall, ex_u_stall, ex_v_stall, ex_u_taken, ex_v_taken, wb_v_taken} = '0;
        {ex_fix_addr, wb_fix_addr} = '0;
        {in_dst, in_src_a, in_src_b, in_dst_en, in_simple, gap} = {24'h21_43_65, 6'h3e};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        test_fetch();
        test_pair(8'h43, 2'h3, 1'b1);
        test_pair(8'h13, 2'h3, 1'b0);
        test_pair(8'h43, 2'h1, 1'b0);
        test_prefix(2'h2, 1'b0, 1'b0, 2);
        test_prefix(2'h0, 1'b1, 1'b1, 0);
        test_prefix(2'h0, 1'b1, 1'b0, 1);
        test_ex();
        test_miss(1'b0, 2);
        test_miss(1'b1, 3);
        end_sim();
    end
endmodule : dual_issue_integer_pipeline_tb_top
